// ==== rtl/optpt_pkg.sv ====
// Shared constants, register map and types of the one-shot trigger pulse timer.
package optpt_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EDGE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CCR0 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CCR1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CNT = 8'h14;
  localparam int unsigned CTL0_RUN_BIT = 7;
  localparam int unsigned CTL1_SOFT_BIT = 6;
  localparam int unsigned CTL1_BUSY_BIT = 7;
  localparam logic [2:0] MODE_EXTPULSE = 3'h2;
  localparam logic [2:0] MODE_ONESHOT = 3'h3;
  localparam logic [2:0] PRESC_RST = 3'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_IDLE = 16'hFFFF;
  localparam logic [CNT_W-1:0] CCR_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  typedef struct packed {
    logic run;
    logic [2:0] prescale;
    logic [2:0] mode;
    logic [1:0] event_edge_sel;
    logic [1:0] trigger_edge_sel;
  } optpt_cfg_t;

  typedef enum logic [1:0] {
    S_STOP,
    S_WAIT,
    S_COUNT
  } optpt_state_t;

  function automatic logic optpt_hit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
    optpt_hit = (cnt == cmp);
  endfunction
endpackage

// ==== rtl/optpt_presc.sv ====
// Count clock enable generator dividing the system clock by a power of two.
`timescale 1ns/10ps
`default_nettype none
module optpt_presc #(
  parameter int unsigned DIV_W = 7
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;

  always_comb
  begin
    mask = DIV_W'((1 << sel) - 1);
  end

  assign tick = ((div_q & mask) == mask);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + DIV_W'(1);
    end
  end
endmodule // optpt_presc
`default_nettype wire

// ==== rtl/optpt_edge.sv ====
// Valid edge detector for the external trigger input.
`timescale 1ns/10ps
`default_nettype none
module optpt_edge (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic trig_in,
  input wire logic [1:0] sel,
  output logic edge_pulse
);
  logic prev_q;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= trig_in;
    end
  end

  always_comb
  begin
    case (sel)
      optpt_pkg::EDGE_NONE: edge_pulse = 1'b0;
      optpt_pkg::EDGE_RISE: edge_pulse = trig_in & ~prev_q;
      optpt_pkg::EDGE_FALL: edge_pulse = ~trig_in & prev_q;
      default: edge_pulse = trig_in ^ prev_q;
    endcase
  end
endmodule // optpt_edge
`default_nettype wire

// ==== rtl/optpt_timer.sv ====
// Sixteen-bit pulse timer with one-shot and external trigger pulse modes behind an APB slave.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Trigger after second compare event clears counter, asserts pulse, keeps counting.
// - Trigger just before second match suppresses its event; pulse stays active.
// - Trigger after first compare event clears counter; active period lengthens.
// - Trigger just before first match suppresses event, clears, asserts pulse.
// - External trigger mode raises second compare event on the match cycle.
// - Modes other than external trigger and one-shot raise second compare event on the count after the match.
// - One-shot mode raises second compare event on the match cycle itself.
// - Mode one-shot with run set waits for trigger, then makes one pulse.
// - Hardware edge or software trigger bit starts the one-shot.
// - Software-started one-shot drives aux output while counting only.
// - Accepted trigger moves counter from all ones to zero, counts up.
// - After the pulse the counter reloads all ones, stops and waits.
// - Triggers during a running one-shot pulse are ignored.
// - Delay equals second compare; width equals first minus second plus one.
// - First event follows count after first match; second on second match.
// - Second compare match raises its event and asserts the pulse output.
// - First compare match raises its event, drops the pulse, stops counting.
// - Compare writes act at once; lower values force a wrap first.
module optpt_timer #(
  parameter int unsigned PRESC_W = 7
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [optpt_pkg::ADDR_W-1:0] paddr,
  input wire logic [optpt_pkg::DATA_W-1:0] pwdata,
  output logic [optpt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trigger_in,
  output logic pulse_output,
  output logic aux_output,
  output logic period_match_irq,
  output logic delay_match_irq
);
  optpt_pkg::optpt_cfg_t cfg_q;
  optpt_pkg::optpt_state_t st_q;
  optpt_pkg::optpt_state_t st_d;
  logic [optpt_pkg::CNT_W-1:0] ccr0_q;
  logic [optpt_pkg::CNT_W-1:0] ccr1_q;
  logic [optpt_pkg::CNT_W-1:0] cnt_q;
  logic [optpt_pkg::CNT_W-1:0] cnt_d;
  logic [optpt_pkg::CNT_W-1:0] nxt;
  logic pulse_q;
  logic pulse_d;
  logic soft_q;
  logic soft_d;
  logic irq0_d;
  logic irq1_d;
  logic pend_q;
  logic pend_soft_q;
  logic tick;
  logic hw_edge;
  logic soft_trig;
  logic accept;
  logic wr;
  logic rd_setup;
  logic mapped;
  logic os_mode;
  logic ext_mode;

  assign os_mode = (cfg_q.mode == optpt_pkg::MODE_ONESHOT);
  assign ext_mode = (cfg_q.mode == optpt_pkg::MODE_EXTPULSE);

  optpt_presc #(
    .DIV_W(PRESC_W)
  ) u_presc (
    .ref_clk(ref_clk),
    .srst(srst),
    .sel(cfg_q.prescale),
    .tick(tick)
  );

  optpt_edge u_edge (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig_in(ext_trigger_in),
    .sel(cfg_q.trigger_edge_sel),
    .edge_pulse(hw_edge)
  );

  // APB slave with zero wait states.
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb
  begin
    case (paddr)
      optpt_pkg::OFF_CTL0, optpt_pkg::OFF_CTL1, optpt_pkg::OFF_EDGE,
      optpt_pkg::OFF_CCR0, optpt_pkg::OFF_CCR1, optpt_pkg::OFF_CNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  assign soft_trig = wr & (paddr == optpt_pkg::OFF_CTL1) & pwdata[optpt_pkg::CTL1_SOFT_BIT];

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cfg_q <= '{run: 1'b0, prescale: optpt_pkg::PRESC_RST, mode: optpt_pkg::MODE_RST,
                 event_edge_sel: optpt_pkg::EDGE_RST, trigger_edge_sel: optpt_pkg::EDGE_RST};
    end
    else if (wr)
    begin
      case (paddr)
        optpt_pkg::OFF_CTL0:
        begin
          cfg_q.run <= pwdata[optpt_pkg::CTL0_RUN_BIT];
          cfg_q.prescale <= pwdata[2:0];
        end
        optpt_pkg::OFF_CTL1: cfg_q.mode <= pwdata[2:0];
        optpt_pkg::OFF_EDGE:
        begin
          cfg_q.event_edge_sel <= pwdata[3:2];
          cfg_q.trigger_edge_sel <= pwdata[1:0];
        end
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // compare writes act on the next comparison.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ccr0_q <= optpt_pkg::CCR_RST;
      ccr1_q <= optpt_pkg::CCR_RST;
    end
    else if (wr)
    begin
      if (paddr == optpt_pkg::OFF_CCR0)
        ccr0_q <= pwdata[optpt_pkg::CNT_W-1:0];
      if (paddr == optpt_pkg::OFF_CCR1)
        ccr1_q <= pwdata[optpt_pkg::CNT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      prdata <= '0;
    else if (rd_setup)
      case (paddr)
        optpt_pkg::OFF_CTL0: prdata <= {24'h000000, cfg_q.run, 4'h0, cfg_q.prescale};
        optpt_pkg::OFF_CTL1: prdata <= {24'h000000, (st_q == optpt_pkg::S_COUNT), 4'h0, cfg_q.mode};
        optpt_pkg::OFF_EDGE: prdata <= {28'h0000000, cfg_q.event_edge_sel, cfg_q.trigger_edge_sel};
        optpt_pkg::OFF_CCR0: prdata <= {16'h0000, ccr0_q};
        optpt_pkg::OFF_CCR1: prdata <= {16'h0000, ccr1_q};
        optpt_pkg::OFF_CNT: prdata <= {16'h0000, cnt_q};
        default: prdata <= '0;
      endcase
  end

  // one-shot triggers count only while waiting.
  assign accept = cfg_q.run & (hw_edge | soft_trig) &
                  ((os_mode & (st_q == optpt_pkg::S_WAIT)) | ext_mode);

  // Pending trigger is applied at the next count clock; a new trigger wins over the clear.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pend_q <= 1'b0;
      pend_soft_q <= 1'b0;
    end
    else if (accept)
    begin
      pend_q <= 1'b1;
      pend_soft_q <= soft_trig;
    end
    else if (~cfg_q.run | tick)
    begin
      pend_q <= 1'b0;
      pend_soft_q <= 1'b0;
    end
  end

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    pulse_d = pulse_q;
    soft_d = soft_q;
    irq0_d = 1'b0;
    irq1_d = 1'b0;
    nxt = cnt_q + optpt_pkg::CNT_ONE;
    if (~cfg_q.run)
    begin
      st_d = optpt_pkg::S_STOP;
      cnt_d = optpt_pkg::CNT_IDLE;
      pulse_d = 1'b0;
      soft_d = 1'b0;
    end
    else if (st_q == optpt_pkg::S_STOP)
    begin
      // arm and wait for a trigger in one-shot and external modes; other modes count from zero.
      st_d = (os_mode | ext_mode) ? optpt_pkg::S_WAIT : optpt_pkg::S_COUNT;
      cnt_d = (os_mode | ext_mode) ? optpt_pkg::CNT_IDLE : optpt_pkg::CNT_ZERO;
    end
    // advance only on the count enable.
    else if (tick)
    begin
      case (cfg_q.mode)
        optpt_pkg::MODE_ONESHOT:
        begin
          if (st_q == optpt_pkg::S_WAIT)
          begin
            if (pend_q)
            begin
              st_d = optpt_pkg::S_COUNT;
              cnt_d = optpt_pkg::CNT_ZERO;
              soft_d = pend_soft_q;
              if (optpt_pkg::optpt_hit(optpt_pkg::CNT_ZERO, ccr1_q))
              begin
                irq1_d = 1'b1;
                pulse_d = 1'b1;
              end
            end
          end
          else if (optpt_pkg::optpt_hit(cnt_q, ccr0_q))
          begin
            irq0_d = 1'b1;
            pulse_d = 1'b0;
            soft_d = 1'b0;
            cnt_d = optpt_pkg::CNT_IDLE;
            st_d = optpt_pkg::S_WAIT;
          end
          else
          begin
            cnt_d = nxt;
            if (optpt_pkg::optpt_hit(nxt, ccr1_q))
            begin
              irq1_d = 1'b1;
              pulse_d = 1'b1;
            end
          end
        end
        optpt_pkg::MODE_EXTPULSE:
        begin
          if (pend_q)
          begin
            st_d = optpt_pkg::S_COUNT;
            cnt_d = optpt_pkg::CNT_ZERO;
            pulse_d = 1'b1;
          end
          else if (st_q == optpt_pkg::S_COUNT)
          begin
            if (optpt_pkg::optpt_hit(cnt_q, ccr0_q))
            begin
              irq0_d = 1'b1;
              cnt_d = optpt_pkg::CNT_ZERO;
              pulse_d = 1'b1;
            end
            else
            begin
              cnt_d = nxt;
              // second event with the output change.
              if (optpt_pkg::optpt_hit(nxt, ccr1_q))
              begin
                irq1_d = 1'b1;
                pulse_d = 1'b0;
              end
            end
          end
        end
        default:
        begin
          if (optpt_pkg::optpt_hit(cnt_q, ccr0_q))
          begin
            irq0_d = 1'b1;
            cnt_d = optpt_pkg::CNT_ZERO;
          end
          else
            cnt_d = nxt;
          // second event on the count after the match.
          if (optpt_pkg::optpt_hit(cnt_q, ccr1_q))
            irq1_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_q <= optpt_pkg::S_STOP;
      cnt_q <= optpt_pkg::CNT_IDLE;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pulse_q <= 1'b0;
      soft_q <= 1'b0;
      period_match_irq <= 1'b0;
      delay_match_irq <= 1'b0;
    end
    else
    begin
      pulse_q <= pulse_d;
      soft_q <= soft_d;
      period_match_irq <= irq0_d;
      delay_match_irq <= irq1_d;
    end
  end

  assign pulse_output = pulse_q;
  // aux output follows a software-started one-shot count.
  assign aux_output = soft_q & (st_q == optpt_pkg::S_COUNT) & os_mode;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  trig_clear_pulse_a: assert property (cfg_q.run && ext_mode && st_q != optpt_pkg::S_STOP && tick && pend_q |=>
    cnt_q == optpt_pkg::CNT_ZERO && pulse_output) else $error("trigger did not restart pulse");
  trig_suppress_a: assert property (cfg_q.run && ext_mode && st_q != optpt_pkg::S_STOP && tick && pend_q |=>
    !delay_match_irq && !period_match_irq) else $error("compare event not suppressed");
  ext_irq_align_a: assert property (delay_match_irq && ext_mode |->
    cnt_q == ccr1_q && !pulse_output) else $error("ext mode second event misaligned");
  other_irq_late_a: assert property (delay_match_irq && !ext_mode && !os_mode && $stable(cfg_q) |->
    $past(cnt_q) == ccr1_q) else $error("second event not after match");
  os_irq_align_a: assert property (delay_match_irq && os_mode |->
    cnt_q == ccr1_q && pulse_output) else $error("one-shot second event misaligned");
  os_wait_idle_a: assert property (os_mode && st_q == optpt_pkg::S_WAIT |->
    cnt_q == optpt_pkg::CNT_IDLE && !pulse_output) else $error("waiting counter not idle");
  os_start_zero_a: assert property (os_mode && st_q == optpt_pkg::S_WAIT && pend_q && tick && cfg_q.run |=>
    cnt_q == optpt_pkg::CNT_ZERO && st_q == optpt_pkg::S_COUNT) else $error("start did not clear counter");
  os_end_reload_a: assert property (period_match_irq && os_mode |->
    cnt_q == optpt_pkg::CNT_IDLE && st_q == optpt_pkg::S_WAIT && !pulse_output) else $error("pulse end wrong");
  os_ignore_trig_a: assert property (os_mode && cfg_q.run && st_q == optpt_pkg::S_COUNT && tick &&
    cnt_q != ccr0_q |=> cnt_q == $past(cnt_q) + optpt_pkg::CNT_ONE) else $error("running one-shot disturbed");
  hold_no_tick_a: assert property (cfg_q.run && st_q == optpt_pkg::S_COUNT && !tick && !pend_q |=>
    $stable(cnt_q)) else $error("counter moved without enable");
  aux_level_a: assert property ($rose(aux_output) |->
    $past(pend_soft_q) && cnt_q == optpt_pkg::CNT_ZERO) else $error("aux output without soft start");

  os_pulse_c: cover property (os_mode && delay_match_irq ##[1:300] period_match_irq);
  ext_restart_c: cover property (ext_mode && pend_q && tick && pulse_q);
  soft_start_c: cover property (aux_output);
endmodule // optpt_timer
`default_nettype wire

// ==== test/optpt_far_end.sv ====
// Trigger source and pulse load model at the far side of the timer.
`timescale 1ns/10ps
`default_nettype none
module optpt_far_end (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic fire,
  input wire logic pulse_in,
  output logic trig,
  output logic [15:0] last_width
);
  logic [15:0] run_q;
  // The trigger line toggles once per request, so each request is one edge.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      trig <= 1'b0;
    else if (fire)
      trig <= ~trig;
  end
  // The load measures the width of each completed pulse.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      run_q <= 16'h0000;
      last_width <= 16'h0000;
    end
    else if (pulse_in)
      run_q <= run_q + 16'h0001;
    else if (run_q != 16'h0000)
    begin
      last_width <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule // optpt_far_end
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking testbench of the one-shot trigger pulse timer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, er, fire;
  logic ext_trigger_in, pulse_output, aux_output, period_match_irq, delay_match_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cnt_rd;
  logic [15:0] far_w;
  int failures, n_tests, rise, wid, dirq, pirq, auxn, nrise, c1, c0;

  optpt_timer i_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trigger_in(ext_trigger_in), .pulse_output(pulse_output),
    .aux_output(aux_output), .period_match_irq(period_match_irq), .delay_match_irq(delay_match_irq));
  optpt_far_end i_far (.ref_clk(ref_clk), .srst(srst), .fire(fire), .pulse_in(pulse_output),
    .trig(ext_trigger_in), .last_width(far_w));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k >= 16)
    begin
      failures++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic shot(input int pr, input int md, input int sel, input int sw);
    logic pv;
    int lim;
    apb(1'b1, optpt_pkg::OFF_CTL0, 32'(pr));
    apb(1'b1, optpt_pkg::OFF_EDGE, 32'(sel));
    apb(1'b1, optpt_pkg::OFF_CCR0, 32'(c0));
    apb(1'b1, optpt_pkg::OFF_CCR1, 32'(c1));
    apb(1'b1, optpt_pkg::OFF_CTL1, 32'(md));
    apb(1'b1, optpt_pkg::OFF_CTL0, 32'h80 | 32'(pr));
    rise = -1; wid = 0; dirq = -1; pirq = -1; auxn = 0; nrise = 0; pv = 1'b0;
    if (sw != 0)
      apb(1'b1, optpt_pkg::OFF_CTL1, 32'h40 | 32'(md));
    else
    begin
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
    end
    lim = ((c0 + 4) << pr) + 20;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge ref_clk);
      if (pulse_output === 1'b1 && pv === 1'b0) nrise++;
      if (pulse_output === 1'b1 && rise < 0) rise = i;
      if (pulse_output === 1'b1 && nrise == 1) wid++;
      if (delay_match_irq === 1'b1 && dirq < 0) dirq = i;
      if (period_match_irq === 1'b1 && pirq < 0) pirq = i;
      if (aux_output === 1'b1) auxn++;
      pv = pulse_output;
      // retrigger while counting, and again inside a wide pulse.
      fire <= (sel == 3 && sw == 0 && (i == 1 || (md == 3 && i == rise && c0 - c1 >= 2)));
    end
    apb(1'b0, optpt_pkg::OFF_CNT, 32'h0);
    cnt_rd = rd;
    apb(1'b1, optpt_pkg::OFF_CTL0, 32'(pr));
  endtask

  task automatic judge(input int pr, input int sw);
    int w;
    w = (c0 - c1 + 1) << pr;
    chk(32'(wid), 32'(w));
    chk({16'h0000, far_w}, 32'(w));
    chk(32'(nrise), 32'h1);
    chk(32'(dirq), 32'(rise));
    chk(32'(pirq), 32'(rise + wid));
    chk(32'(rise >= (c1 << pr) && rise <= (c1 << pr) + (2 << pr) + 3), 32'h1);
    if (sw != 0)
      chk(32'(auxn >= ((c0 + 1) << pr) && auxn <= ((c0 + 2) << pr)), 32'h1);
    else
      chk(32'(auxn), 32'h0);
    chk(32'(aux_output), 32'h0);
    chk(cnt_rd, 32'h0000FFFF);
  endtask

  initial
  begin
    logic [7:0] ads [7];
    logic [31:0] exv [7];
    ads = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    exv = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h0};
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; fire = 1'b0;
    failures = 0;
    n_tests = 0;
    void'($urandom(32'hEEF15AD3));
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ads[i], 32'h0);
      chk(rd, exv[i]);
      chk(32'(er), 32'(i == 6));
    end
    $display("test reset values done");
    c1 = 2;
    c0 = 4;
    for (int s = 1; s < 4; s++)
    begin
      shot(0, 3, s, 0);
      judge(0, 0);
    end
    $display("test edge triggers done");
    c1 = 3;
    c0 = 6;
    shot(0, 3, 3, 1);
    judge(0, 1);
    c1 = 1;
    c0 = 3;
    shot(1, 3, 3, 0);
    judge(1, 0);
    $display("test soft trigger and prescale done");
    for (int r = 0; r < 3; r++)
    begin
      c1 = 1 + int'($urandom % 6);
      c0 = c1 + int'($urandom % 8);
      shot(0, 3, 3, 0);
      judge(0, 0);
    end
    $display("test random shots done");
    apb(1'b1, optpt_pkg::OFF_CTL0, 32'h0);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    nrise = 0;
    repeat (30)
    begin
      @(posedge ref_clk);
      if (pulse_output !== 1'b0) nrise++;
    end
    chk(32'(nrise), 32'h0);
    c1 = 3;
    c0 = 6;
    shot(0, 2, 3, 0);
    chk(32'(dirq), 32'(rise + wid));
    shot(0, 0, 3, 0);
    chk(32'(pirq - dirq), 32'(c0 - c1));
    $display("test stopped, external and interval modes done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
